//--- iocfg_defines.svh
`ifndef IOCFG_DEFINES_SVH
`define IOCFG_DEFINES_SVH

// ----------------------------------------------------------------------
// Offsets in I/O space
// ----------------------------------------------------------------------
`define IOCFG_ADDR_GDATA 6'h07
`define IOCFG_ADDR_OSC 6'h0a
`define IOCFG_ADDR_TRIM 6'h0b
`define IOCFG_ADDR_EDGE 6'h0c
`define IOCFG_ADDR_PAEN 6'h0d

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define IOCFG_OSC_XEN_BIT 7
`define IOCFG_OSC_DRV_HI 6
`define IOCFG_OSC_DRV_LO 5
`define IOCFG_OSC_PD_BIT 0
`define IOCFG_EDGE_TMR_BIT 4
`define IOCFG_EDGE_PB0_HI 3
`define IOCFG_EDGE_PB0_LO 2
`define IOCFG_EDGE_PA0_HI 1
`define IOCFG_EDGE_PA0_LO 0
`define IOCFG_RST_GDATA 8'h00
`define IOCFG_RST_OSC 8'h00
`define IOCFG_RST_TRIM 8'h00
`define IOCFG_RST_EDGE 8'h00
`define IOCFG_RST_PAEN 8'hff
`define IOCFG_RD_WO 8'h00
// Pins whose enable also gates the digital input path.
`define IOCFG_DIN_PINS 8'hd8

`endif

//--- iocfg_pkg.sv
`default_nettype none
package iocfg_pkg;
  // Crystal oscillator and power-down settings.
  typedef struct packed {
    logic xtal_en;
    logic [1:0] drive;
    logic bg_lvr_pd;
  } iocfg_osc_s;

  // Interrupt edge selections.
  typedef struct packed {
    logic tmr_fall;
    logic [1:0] pb0_sel;
    logic [1:0] pa0_sel;
  } iocfg_edge_s;

  // Bit operations on the data byte.
  typedef enum logic [1:0] {
    IOCFG_BIT_NONE = 2'b00,
    IOCFG_BIT_FLIP = 2'b01,
    IOCFG_BIT_HOLD_UNTIL_CLEAR_INSTR = 2'b10,
    IOCFG_BIT_HOLD_UNTIL_SET_INSTR = 2'b11
  } iocfg_bitop_e;

  // Interrupt request flags.
  typedef struct packed {
    logic tmr;
    logic pb0;
    logic pa0;
  } iocfg_irq_s;
endpackage
`default_nettype wire

//--- iocfg_bank.sv
`include "iocfg_defines.svh"
`default_nettype none
module iocfg_bank #(
  parameter bit EMU_BUILD = 1'b0
) (
  // Clock, resets and enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic wdt_reset,
  input wire logic ce,
  // I/O-space access
  input wire logic [5:0] io_addr,
  input wire logic io_we,
  input wire logic io_re,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Bit operations on the data byte
  input wire iocfg_pkg::iocfg_bitop_e bit_op,
  input wire logic [2:0] bit_sel,
  output logic bit_hold,
  // Settings toward oscillators, power and interrupt edges
  output iocfg_pkg::iocfg_osc_s osc_cfg,
  output logic [7:0] rc_trim,
  output iocfg_pkg::iocfg_edge_s edge_cfg,
  // Port A control
  output logic [7:0] pa_din_en,
  output logic [7:0] pa_wake_en,
  // Event sources and results
  input wire logic [7:0] pa_pin,
  input wire logic pb0_pin,
  input wire logic tmr_bit,
  input wire iocfg_pkg::iocfg_irq_s irq_clr,
  output iocfg_pkg::iocfg_irq_s irq_flag,
  output logic wake_evt
);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Edge match for a two-bit select: both, rising, falling, reserved.
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic rise,
                                    input logic fall);
    edge_hit = 1'b0;
    case (sel)
      2'b00: edge_hit = rise | fall;
      2'b01: edge_hit = rise;
      2'b10: edge_hit = fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
    hit = (a == b);
  endfunction

  logic [7:0] gdata_q;
  logic [7:0] trim_q;
  logic [7:0] paen_q;
  logic [7:0] pa_meta_q;
  logic [7:0] pa_sync_q;
  logic [7:0] pa_prev_q;
  logic pb0_meta_q;
  logic pb0_sync_q;
  logic pb0_prev_q;
  logic tmr_prev_q;
  logic wake_q;
  logic [7:0] rdata_q;
  iocfg_pkg::iocfg_osc_s osc_q;
  iocfg_pkg::iocfg_edge_s edge_q;
  iocfg_pkg::iocfg_irq_s irq_q;
  iocfg_pkg::iocfg_irq_s irq_set;
  logic [7:0] en_eff;
  logic cur_bit;
  logic wr_gdata;

  // --------------------------------------------------------------------
  // General data byte
  // --------------------------------------------------------------------
  assign wr_gdata = io_we && hit(io_addr, `IOCFG_ADDR_GDATA);
  assign cur_bit = gdata_q[bit_sel];

  // Only the main reset clears it; a watchdog restart must not lose it.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      gdata_q <= `IOCFG_RST_GDATA;
    else if (ce)
    begin
      if (wr_gdata)
        gdata_q <= io_wdata;
      else if (bit_op == iocfg_pkg::IOCFG_BIT_FLIP)
        gdata_q[bit_sel] <= ~gdata_q[bit_sel];
    end
  end

  // The CPU stalls while the tested bit has not reached its target.
  always_comb
  begin
    case (bit_op)
      iocfg_pkg::IOCFG_BIT_HOLD_UNTIL_CLEAR_INSTR: bit_hold = cur_bit;
      iocfg_pkg::IOCFG_BIT_HOLD_UNTIL_SET_INSTR: bit_hold = ~cur_bit;
      default: bit_hold = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Write-only settings
  // --------------------------------------------------------------------
  // A watchdog restart returns every setting to its reset value.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      osc_q <= '0;
    else if (ce)
    begin
      if (wdt_reset)
        osc_q <= '0;
      else if (io_we && hit(io_addr, `IOCFG_ADDR_OSC))
      begin
        osc_q.xtal_en <= io_wdata[`IOCFG_OSC_XEN_BIT];
        osc_q.drive <=
          io_wdata[`IOCFG_OSC_DRV_HI:`IOCFG_OSC_DRV_LO];
        osc_q.bg_lvr_pd <= io_wdata[`IOCFG_OSC_PD_BIT];
      end
    end
  end

  // Trim is written only by calibration code at start-up.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      trim_q <= `IOCFG_RST_TRIM;
    else if (ce)
    begin
      if (wdt_reset)
        trim_q <= `IOCFG_RST_TRIM;
      else if (io_we && hit(io_addr, `IOCFG_ADDR_TRIM))
        trim_q <= io_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      edge_q <= '0;
    else if (ce)
    begin
      if (wdt_reset)
        edge_q <= '0;
      else if (io_we && hit(io_addr, `IOCFG_ADDR_EDGE))
      begin
        edge_q.tmr_fall <= io_wdata[`IOCFG_EDGE_TMR_BIT];
        edge_q.pb0_sel <=
          io_wdata[`IOCFG_EDGE_PB0_HI:`IOCFG_EDGE_PB0_LO];
        edge_q.pa0_sel <=
          io_wdata[`IOCFG_EDGE_PA0_HI:`IOCFG_EDGE_PA0_LO];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      paen_q <= `IOCFG_RST_PAEN;
    else if (ce)
    begin
      if (wdt_reset)
        paen_q <= `IOCFG_RST_PAEN;
      else if (io_we && hit(io_addr, `IOCFG_ADDR_PAEN))
        paen_q <= io_wdata;
    end
  end

  // Emulator silicon reads the stored bits with opposite sense.
  assign en_eff = EMU_BUILD ? ~paen_q : paen_q;
  assign pa_din_en = en_eff & `IOCFG_DIN_PINS;
  assign pa_wake_en = en_eff;
  assign osc_cfg = osc_q;
  assign rc_trim = trim_q;
  assign edge_cfg = edge_q;

  // --------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------
  // Reads have no side effect; write-only registers give a fixed filler.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 8'h00;
    else if (ce && io_re)
    begin
      if (hit(io_addr, `IOCFG_ADDR_GDATA))
        rdata_q <= gdata_q;
      else
        rdata_q <= `IOCFG_RD_WO;
    end
  end
  assign io_rdata = rdata_q;

  // --------------------------------------------------------------------
  // Pin synchronisers and edge history
  // --------------------------------------------------------------------
  // Pins are asynchronous; two stages before any logic looks at them.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pa_meta_q <= 8'h00;
      pa_sync_q <= 8'h00;
      pa_prev_q <= 8'h00;
      pb0_meta_q <= 1'b0;
      pb0_sync_q <= 1'b0;
      pb0_prev_q <= 1'b0;
      tmr_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      pa_meta_q <= pa_pin;
      pa_sync_q <= pa_meta_q;
      pa_prev_q <= pa_sync_q;
      pb0_meta_q <= pb0_pin;
      pb0_sync_q <= pb0_meta_q;
      pb0_prev_q <= pb0_sync_q;
      tmr_prev_q <= tmr_bit;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt request flags
  // --------------------------------------------------------------------
  always_comb
  begin
    irq_set.tmr = edge_q.tmr_fall ? (tmr_prev_q & ~tmr_bit)
                                  : (~tmr_prev_q & tmr_bit);
    irq_set.pb0 = edge_hit(edge_q.pb0_sel, ~pb0_prev_q & pb0_sync_q,
                           pb0_prev_q & ~pb0_sync_q);
    irq_set.pa0 = en_eff[0] &
                  edge_hit(edge_q.pa0_sel, ~pa_prev_q[0] & pa_sync_q[0],
                           pa_prev_q[0] & ~pa_sync_q[0]);
  end

  // A new edge in the clearing cycle keeps the flag set.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_q <= '0;
    else if (ce)
    begin
      if (wdt_reset)
        irq_q <= '0;
      else
        irq_q <= irq_set | (irq_q & ~irq_clr);
    end
  end
  assign irq_flag = irq_q;

  // --------------------------------------------------------------------
  // Wake-up on enabled pin toggles
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wake_q <= 1'b0;
    else if (ce)
      wake_q <= |((pa_sync_q ^ pa_prev_q) & en_eff);
  end
  assign wake_evt = wake_q;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Registers update one edge after the strobe, so most checks use |=>.
  gdata_write_a: assert property (ce && wr_gdata |=>
      gdata_q == $past(io_wdata))
    else $error("data byte write lost");
  gdata_wdt_a: assert property (ce && wdt_reset && !wr_gdata &&
      bit_op != iocfg_pkg::IOCFG_BIT_FLIP |=> $stable(gdata_q))
    else $error("data byte changed by watchdog");
  bit_flip_a: assert property (ce && !wr_gdata &&
      bit_op == iocfg_pkg::IOCFG_BIT_FLIP |=>
      gdata_q == ($past(gdata_q) ^ (8'h01 << $past(bit_sel))))
    else $error("bit flip wrong");
  bit_wait_a: assert property (
      bit_op == iocfg_pkg::IOCFG_BIT_HOLD_UNTIL_SET_INSTR |-> bit_hold == !gdata_q[bit_sel])
    else $error("wait hold wrong");
  osc_write_a: assert property (ce && !wdt_reset && io_we &&
      io_addr == `IOCFG_ADDR_OSC |=> osc_cfg.xtal_en == $past(io_wdata[7])
      && osc_cfg.drive == $past(io_wdata[6:5])
      && osc_cfg.bg_lvr_pd == $past(io_wdata[0]))
    else $error("oscillator setting wrong");
  trim_write_a: assert property (ce && !wdt_reset && io_we &&
      io_addr == `IOCFG_ADDR_TRIM |=> rc_trim == $past(io_wdata))
    else $error("trim not stored");
  en_polarity_a: assert property (ce && !wdt_reset && io_we &&
      io_addr == `IOCFG_ADDR_PAEN |=>
      pa_wake_en == ($past(io_wdata) ^ {8{EMU_BUILD}}))
    else $error("enable polarity wrong");
  din_mask_a: assert property ((pa_din_en & 8'h27) == 8'h00)
    else $error("digital input on wake-only pin");
  wake_gate_a: assert property (ce && ((pa_sync_q ^ pa_prev_q) &
      pa_wake_en) == 8'h00 |=> !wake_evt)
    else $error("wake from disabled pin");
  pa0_block_a: assert property (ce && !pa_wake_en[0] &&
      !irq_flag.pa0 |=> !irq_flag.pa0)
    else $error("pin 0 request while disabled");
  flag_hold_a: assert property (ce && !wdt_reset && irq_q.pa0 &&
      !irq_clr.pa0 |=> irq_flag.pa0)
    else $error("request flag dropped");
  set_wins_a: assert property (ce && !wdt_reset && irq_set.tmr |=>
      irq_flag.tmr)
    else $error("timer request lost");
  read_quiet_a: assert property (ce && io_re && !io_we &&
      !wdt_reset |=> $stable(osc_q) && $stable(paen_q))
    else $error("read changed a setting");

  // Main scenarios the bench is expected to reach.
  wake_seen_c: cover property (wake_evt);
  pa0_irq_c: cover property (irq_flag.pa0 ##1 !irq_flag.pa0);
  flip_c: cover property (bit_op == iocfg_pkg::IOCFG_BIT_FLIP);
  wdt_keep_c: cover property (wdt_reset && gdata_q != 8'h00);

endmodule // iocfg_bank
`default_nettype wire

//--- iocfg_tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wdt_reset = 1'b0;
  logic ce = 1'b1;
  logic [5:0] io_addr = 6'h00;
  logic io_we = 1'b0;
  logic io_re = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  logic [7:0] io_rdata;
  iocfg_pkg::iocfg_bitop_e bit_op = iocfg_pkg::IOCFG_BIT_NONE;
  logic [2:0] bit_sel = 3'h0;
  logic bit_hold;
  iocfg_pkg::iocfg_osc_s osc_cfg;
  logic [7:0] rc_trim;
  iocfg_pkg::iocfg_edge_s edge_cfg;
  logic [7:0] pa_din_en;
  logic [7:0] pa_wake_en;
  logic [7:0] pa_pin = 8'h00;
  logic pb0_pin = 1'b0;
  logic tmr_bit = 1'b0;
  iocfg_pkg::iocfg_irq_s irq_clr = 3'h0;
  iocfg_pkg::iocfg_irq_s irq_flag;
  logic wake_evt;
  logic [2:0] flag_v;
  logic [7:0] emu_din_en;
  logic [7:0] emu_wake_en;
  int bad_count = 0;
  int compares = 0;
  logic [7:0] rd_v;

  assign flag_v = irq_flag;

  // A 40 ns period gives the 25 MHz system clock.
  always #20 clk = ~clk;

  iocfg_bank dut (.clk(clk), .rstn(rstn), .wdt_reset(wdt_reset), .ce(ce),
    .io_addr(io_addr), .io_we(io_we), .io_re(io_re), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .bit_op(bit_op), .bit_sel(bit_sel),
    .bit_hold(bit_hold), .osc_cfg(osc_cfg), .rc_trim(rc_trim),
    .edge_cfg(edge_cfg), .pa_din_en(pa_din_en), .pa_wake_en(pa_wake_en),
    .pa_pin(pa_pin), .pb0_pin(pb0_pin), .tmr_bit(tmr_bit),
    .irq_clr(irq_clr), .irq_flag(irq_flag), .wake_evt(wake_evt));

  // A second copy built for the emulator shares all inputs with dut.
  iocfg_bank #(.EMU_BUILD(1'b1)) dut_emu (.clk(clk), .rstn(rstn),
    .wdt_reset(wdt_reset), .ce(ce), .io_addr(io_addr), .io_we(io_we),
    .io_re(io_re), .io_wdata(io_wdata), .io_rdata(), .bit_op(bit_op),
    .bit_sel(bit_sel), .bit_hold(), .osc_cfg(), .rc_trim(), .edge_cfg(),
    .pa_din_en(emu_din_en), .pa_wake_en(emu_wake_en), .pa_pin(pa_pin),
    .pb0_pin(pb0_pin), .tmr_bit(tmr_bit), .irq_clr(irq_clr),
    .irq_flag(), .wake_evt());

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One write; the strobe drops at the edge that takes it.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_we <= 1'b1;
    @(posedge clk);
    io_we <= 1'b0;
    #1;
  endtask

  // Read data is registered, so it is sampled after the taking edge.
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    io_addr <= a;
    io_re <= 1'b1;
    @(posedge clk);
    io_re <= 1'b0;
    #1;
    rd_v = io_rdata;
  endtask

  task automatic bitop(input iocfg_pkg::iocfg_bitop_e op, input int s);
    @(posedge clk);
    bit_op <= op;
    bit_sel <= 3'(s);
    @(posedge clk);
    bit_op <= iocfg_pkg::IOCFG_BIT_NONE;
  endtask

  // Watches six cycles, long enough for the two sync stages and compare.
  task automatic watch(output logic w);
    w = 1'b0;
    repeat (6)
    begin
      @(posedge clk);
      #1;
      w = w | wake_evt;
    end
  endtask

  task automatic clear_flags();
    @(posedge clk);
    irq_clr <= 3'h7;
    @(posedge clk);
    irq_clr <= 3'h0;
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("osc", 8'(osc_cfg), 8'h00);
    check("edge", 8'(edge_cfg), 8'h00);
    check("din", pa_din_en, 8'hd8);
    check("wake_en", pa_wake_en, 8'hff);
    check("emu_din", emu_din_en, 8'h00);
    check("emu_wake", emu_wake_en, 8'h00);
    rd(6'h07);
    check("gdata", rd_v, 8'h00);
    $display("test reset values done");
  endtask

  task automatic t_regs();
    wr(6'h0a, 8'he1);
    check("osc", 8'(osc_cfg), 8'h0f);
    wr(6'h0a, 8'h20);
    check("osc", 8'(osc_cfg), 8'h02);
    wr(6'h0a, 8'hc0);
    check("osc", 8'(osc_cfg), 8'h0c);
    wr(6'h0b, 8'ha5);
    check("trim", rc_trim, 8'ha5);
    wr(6'h0c, 8'h1b);
    check("edge", 8'(edge_cfg), 8'h1b);
    wr(6'h0d, 8'h27);
    check("din_off", pa_din_en, 8'h00);
    check("wake_keep", pa_wake_en, 8'h27);
    foreach (rd_v[i])
    begin
      if (i < 5) rd(6'h0a + 6'(i % 4));
      else rd(6'h3f);
      check("wo_read", rd_v, 8'h00);
    end
    check("osc_kept", 8'(osc_cfg), 8'h0c);
    check("trim_kept", rc_trim, 8'ha5);
    $display("test registers done");
  endtask

  task automatic t_data();
    logic [7:0] d;
    wr(6'h07, 8'h5a);
    rd(6'h07);
    check("gdata", rd_v, 8'h5a);
    bitop(iocfg_pkg::IOCFG_BIT_FLIP, 3);
    bitop(iocfg_pkg::IOCFG_BIT_FLIP, 0);
    bitop(iocfg_pkg::IOCFG_BIT_FLIP, 7);
    rd(6'h07);
    check("flip", rd_v, 8'hd3);
    d = 8'hd3;
    for (int s = 0; s < 8; s++)
    begin
      @(posedge clk);
      bit_op <= iocfg_pkg::IOCFG_BIT_HOLD_UNTIL_CLEAR_INSTR;
      bit_sel <= 3'(s);
      #1;
      check("hold0", 8'(bit_hold), 8'(d[s]));
      @(posedge clk);
      bit_op <= iocfg_pkg::IOCFG_BIT_HOLD_UNTIL_SET_INSTR;
      #1;
      check("hold1", 8'(bit_hold), 8'(!d[s]));
    end
    @(posedge clk);
    bit_op <= iocfg_pkg::IOCFG_BIT_NONE;
    wdt_reset <= 1'b1;
    @(posedge clk);
    wdt_reset <= 1'b0;
    #1;
    check("wdt_osc", 8'(osc_cfg), 8'h00);
    rd(6'h07);
    check("wdt_gdata", rd_v, 8'hd3);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    rd(6'h07);
    check("por_gdata", rd_v, 8'h00);
    $display("test data byte done");
  endtask

  task automatic t_wake(input logic [7:0] m);
    logic w;
    wr(6'h0d, m);
    check("din", pa_din_en, m & 8'hd8);
    check("wake_en", pa_wake_en, m);
    check("emu_wake", emu_wake_en, ~m);
    check("emu_din", emu_din_en, ~m & 8'hd8);
    for (int k = 1; k < 8; k++)
    begin
      @(posedge clk);
      pa_pin[k] <= !pa_pin[k];
      watch(w);
      check("wake", 8'(w), 8'(m[k]));
    end
    $display("test wake done");
  endtask

  // Source 0 is port_a_pin0, 1 is port_b_pin0, 2 the counter bit.
  task automatic t_edge(input int src, input logic [1:0] sel,
                        input logic en, er, ef);
    logic w;
    wr(6'h0c, (src == 2) ? {3'h0, sel[0], 4'h0} :
              (src == 1) ? {4'h0, sel, 2'h0} : {6'h0, sel});
    wr(6'h0d, {7'h7f, en});
    clear_flags();
    for (int e = 0; e < 2; e++)
    begin
      @(posedge clk);
      if (src == 0) pa_pin[0] <= !pa_pin[0];
      else if (src == 1) pb0_pin <= !pb0_pin;
      else tmr_bit <= !tmr_bit;
      watch(w);
      check("flag", 8'(flag_v[src]), 8'(e ? ef : er));
      clear_flags();
      check("cleared", 8'(flag_v[src]), 8'h00);
    end
  endtask

  task automatic final_report();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog: the whole run needs well under 20000 cycles.
  initial
  begin
    #(40 * 20000);
    bad_count++;
    final_report();
  end

  // Main sequence after twelve cycles of reset.
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_regs();
    t_data();
    t_wake(8'ha5);
    t_wake(8'h5a);
    for (int s = 0; s < 2; s++)
    begin
      t_edge(s, 2'b00, 1'b1, 1'b1, 1'b1);
      t_edge(s, 2'b01, 1'b1, 1'b1, 1'b0);
      t_edge(s, 2'b10, 1'b1, 1'b0, 1'b1);
      t_edge(s, 2'b11, 1'b1, 1'b0, 1'b0);
    end
    t_edge(0, 2'b00, 1'b0, 1'b0, 1'b0);
    t_edge(2, 2'b00, 1'b1, 1'b1, 1'b0);
    t_edge(2, 2'b01, 1'b1, 1'b0, 1'b1);
    $display("test edges done");
    final_report();
  end
endmodule // tb
`default_nettype wire
